/* File: rtl/sbc_ctrl_regs.sv */
/*
 supervisor control register bank: hardware setup, watchdog control and
 transceiver mode registers, with their reset, restart and device updates.
 assumes a frame decoder on sys_clk delivering register strobes, and mode
 event pulses from the device state machine on the same clock.
*/
`timescale 1ns/1ns
module sbc_ctrl_regs #(
    parameter int TICKS_PER_MS = sbc_pkg::TICKS_PER_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // register access from the frame decoder
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rd_valid,
    // device mode events
    input  wire logic        soft_reset_evt,
    input  wire logic        restart_entry,
    input  wire logic        stop_to_normal,
    input  wire logic        sleep_entry,
    input  wire logic        failsafe_entry,
    input  wire logic        bus_wake_in_stop,
    input  wire logic        system_error_config,
    input  wire logic        failure_active,
    input  wire logic        fail_output_pin_cfg,
    input  wire logic        restart_lin_wake,
    // device-side field updates
    input  wire logic        dev_wd_upd,
    input  wire logic        dev_wd_stop_lo,
    input  wire logic        dev_wd_start_bus,
    input  wire logic [2:0]  dev_wd_period,
    input  wire logic        dev_bus_upd,
    input  wire logic [1:0]  dev_lin_mode,
    input  wire logic [1:0]  dev_can_mode,
    // hardware setup outputs
    output logic             thermal_wait_select,
    output logic             vs_ov_select,
    output logic             sample_hold_disable,
    output logic             reset_delay_select,
    output logic             soft_reset_pin_option,
    output logic             stop_wdog_disable_hi,
    output logic             fail_output,
    // watchdog outputs
    output logic             wdog_checksum,
    output logic             stop_wdog_disable_lo,
    output logic             wdog_type_select,
    output logic             wdog_start_on_bus_wake,
    output logic      [2:0]  wdog_period_select,
    output logic      [29:0] wdog_period_cycles,
    output logic             wdog_start_long_window,
    // transceiver outputs
    output logic             lin_slope_off,
    output logic             lin_low_slope,
    output logic             lin_tx_dominant_timeout,
    output logic      [1:0]  lin_mode,
    output logic      [1:0]  can_mode,
    output logic             selective_wake
);
    logic        rst_n;
    logic [15:0] hw_reg;
    logic [15:0] wd_reg;
    logic [15:0] bus_reg;
    logic [15:0] next_hw;
    logic [15:0] next_wd;
    logic [15:0] next_bus;
    logic        wr_hw;
    logic        wr_wd;
    logic        wr_bus;

    // address match, shared by write and read decode
    function automatic logic sel(input logic [6:0] addr,
                                 input logic [6:0] target);
        sel = (addr == target);
    endfunction

    // store only writable bits of a host write
    function automatic logic [15:0] merge(input logic [15:0] cur,
                                          input logic [15:0] data,
                                          input logic [15:0] mask);
        merge = (cur & ~mask) | (data & mask);
    endfunction

    sbc_reset_sync u_rst (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .rst_n   (rst_n)
    );

    assign wr_hw  = reg_wr && sel(reg_addr, sbc_pkg::ADDR_HW);
    assign wr_wd  = reg_wr && sel(reg_addr, sbc_pkg::ADDR_WD);
    assign wr_bus = reg_wr && sel(reg_addr, sbc_pkg::ADDR_BUS);

    // hardware setup: run-time updates
    always_comb begin
        next_hw = hw_reg;
        if (stop_to_normal) begin
            next_hw[sbc_pkg::HW_STOP_HI_BIT] = 1'b0;
        end
        if (wr_hw) begin
            next_hw = merge(next_hw, reg_wdata, sbc_pkg::HW_WMASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_reg <= sbc_pkg::HW_POR;
        end else if (soft_reset_evt) begin
            hw_reg <= hw_reg & sbc_pkg::HW_SOFT_KEEP;
        end else if (restart_entry) begin
            hw_reg <= hw_reg & sbc_pkg::HW_RESTART_KEEP;
        end else begin
            hw_reg <= next_hw;
        end
    end

    // watchdog control: run-time updates
    always_comb begin
        next_wd = wd_reg;
        if (dev_wd_upd) begin
            next_wd[sbc_pkg::WD_STOP_LO_BIT] = dev_wd_stop_lo;
            next_wd[sbc_pkg::WD_BUSWAKE_BIT] = dev_wd_start_bus;
            next_wd[sbc_pkg::WD_PER_LSB +: 3] = dev_wd_period;
        end
        if (wr_wd) begin
            next_wd = merge(next_wd, reg_wdata, sbc_pkg::WD_WMASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reg <= sbc_pkg::WD_RST;
        end else if (soft_reset_evt) begin
            wd_reg <= sbc_pkg::WD_RST;
        end else if (restart_entry) begin
            wd_reg <= (wd_reg & sbc_pkg::WD_RESTART_KEEP)
                      | sbc_pkg::WD_RESTART_SET;
        end else begin
            wd_reg <= next_wd;
        end
    end

    // transceiver modes: run-time updates
    always_comb begin
        next_bus = bus_reg;
        if (sleep_entry && !system_error_config
            && bus_reg[sbc_pkg::BUS_CAN_LSB + 1]) begin
            next_bus[sbc_pkg::BUS_CAN_LSB +: 2] = sbc_pkg::MODE_WAKE;
        end
        if (dev_bus_upd) begin
            next_bus[sbc_pkg::BUS_LIN_LSB +: 2] = dev_lin_mode;
            next_bus[sbc_pkg::BUS_CAN_LSB +: 2] = dev_can_mode;
        end
        if (wr_bus) begin
            next_bus = merge(next_bus, reg_wdata, sbc_pkg::BUS_WMASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_reg <= sbc_pkg::BUS_RST;
        end else if (soft_reset_evt) begin
            bus_reg <= sbc_pkg::BUS_RST;
        end else if (restart_entry) begin
            bus_reg <= bus_reg & sbc_pkg::BUS_RESTART_KEEP;
            bus_reg[sbc_pkg::BUS_LIN_Y_BIT] <= restart_lin_wake;
        end else if (failsafe_entry) begin
            bus_reg <= (bus_reg & sbc_pkg::BUS_FS_KEEP)
                       | sbc_pkg::BUS_FS_SET;
        end else begin
            bus_reg <= next_bus;
        end
    end

    // fail output: failure keeps it on regardless of software bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_output <= 1'b0;
        end else begin
            fail_output <= failure_active
                           | (hw_reg[sbc_pkg::HW_SW_FAIL_OUTPUT_ACTIVATE_BIT]
                              & fail_output_pin_cfg);
        end
    end

    // long open window start on bus wake in stop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_start_long_window <= 1'b0;
        end else begin
            wdog_start_long_window <= bus_wake_in_stop
                && wd_reg[sbc_pkg::WD_BUSWAKE_BIT];
        end
    end

    // read port, unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata    <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                if (sel(reg_addr, sbc_pkg::ADDR_HW)) begin
                    reg_rdata <= hw_reg & sbc_pkg::HW_WMASK;
                end else if (sel(reg_addr, sbc_pkg::ADDR_WD)) begin
                    reg_rdata <= wd_reg & sbc_pkg::WD_WMASK;
                end else if (sel(reg_addr, sbc_pkg::ADDR_BUS)) begin
                    reg_rdata <= bus_reg & sbc_pkg::BUS_WMASK;
                end else begin
                    reg_rdata <= 16'h0000;
                end
            end
        end
    end

    sbc_wdog_period #(
        .TICKS_PER_MS (TICKS_PER_MS)
    ) u_period (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .period_sel    (wd_reg[sbc_pkg::WD_PER_LSB +: 3]),
        .period_cycles (wdog_period_cycles)
    );

    // field outputs straight from register bits
    assign thermal_wait_select     = hw_reg[sbc_pkg::HW_THERM_BIT];
    assign vs_ov_select            = hw_reg[sbc_pkg::HW_VSOV_BIT];
    assign sample_hold_disable     = hw_reg[sbc_pkg::HW_SHDIS_BIT];
    assign reset_delay_select      = hw_reg[sbc_pkg::HW_RDEL_BIT];
    assign soft_reset_pin_option   = hw_reg[sbc_pkg::HW_SRPIN_BIT];
    assign stop_wdog_disable_hi    = hw_reg[sbc_pkg::HW_STOP_HI_BIT];
    assign wdog_checksum           = wd_reg[sbc_pkg::WD_CHK_BIT];
    assign stop_wdog_disable_lo    = wd_reg[sbc_pkg::WD_STOP_LO_BIT];
    assign wdog_type_select        = wd_reg[sbc_pkg::WD_TYPE_BIT];
    assign wdog_start_on_bus_wake  = wd_reg[sbc_pkg::WD_BUSWAKE_BIT];
    assign wdog_period_select      = wd_reg[sbc_pkg::WD_PER_LSB +: 3];
    assign lin_slope_off           = bus_reg[sbc_pkg::BUS_FLASH_BIT];
    assign lin_low_slope           = bus_reg[sbc_pkg::BUS_LSM_BIT];
    assign lin_tx_dominant_timeout = bus_reg[sbc_pkg::BUS_TXDTO_BIT];
    assign lin_mode                = bus_reg[sbc_pkg::BUS_LIN_LSB +: 2];
    assign can_mode                = bus_reg[sbc_pkg::BUS_CAN_LSB +: 2];
    assign selective_wake          = bus_reg[sbc_pkg::BUS_CAN_SWK_BIT];
endmodule

/* File: common/sbc_pkg.sv */
/*
 constants for the supervisor control register bank: register addresses,
 write masks, reset and keep patterns, field positions, transceiver mode
 codes and watchdog period figures.
 assumes a 100 MHz system clock and 7-bit register addresses.
*/
package sbc_pkg;
    // register addresses
    localparam logic [6:0]  ADDR_HW          = 7'h02;
    localparam logic [6:0]  ADDR_WD          = 7'h03;
    localparam logic [6:0]  ADDR_BUS         = 7'h04;
    // writable bits, reserved bits stay zero
    localparam logic [15:0] HW_WMASK         = 16'h1E64;
    localparam logic [15:0] WD_WMASK         = 16'h8077;
    localparam logic [15:0] BUS_WMASK        = 16'h00FF;
    // reset values and keep patterns
    localparam logic [15:0] HW_POR           = 16'h0000;
    localparam logic [15:0] HW_SOFT_KEEP     = 16'h0200;
    localparam logic [15:0] HW_RESTART_KEEP  = 16'h1240;
    localparam logic [15:0] WD_RST           = 16'h0014;
    localparam logic [15:0] WD_RESTART_KEEP  = 16'h0010;
    localparam logic [15:0] WD_RESTART_SET   = 16'h0004;
    localparam logic [15:0] BUS_RST          = 16'h0000;
    localparam logic [15:0] BUS_RESTART_KEEP = 16'h00C4;
    localparam logic [15:0] BUS_FS_KEEP      = 16'h00E0;
    localparam logic [15:0] BUS_FS_SET       = 16'h0009;
    // field positions
    localparam int          HW_THERM_BIT     = 12;
    localparam int          HW_VSOV_BIT      = 11;
    localparam int          HW_SHDIS_BIT     = 10;
    localparam int          HW_RDEL_BIT      = 9;
    localparam int          HW_SRPIN_BIT     = 6;
    localparam int          HW_SW_FAIL_OUTPUT_ACTIVATE_BIT     = 5;
    localparam int          HW_STOP_HI_BIT   = 2;
    localparam int          WD_CHK_BIT       = 15;
    localparam int          WD_STOP_LO_BIT   = 6;
    localparam int          WD_TYPE_BIT      = 5;
    localparam int          WD_BUSWAKE_BIT   = 4;
    localparam int          WD_PER_LSB       = 0;
    localparam int          BUS_FLASH_BIT    = 7;
    localparam int          BUS_LSM_BIT      = 6;
    localparam int          BUS_TXDTO_BIT    = 5;
    localparam int          BUS_LIN_LSB      = 3;
    localparam int          BUS_LIN_Y_BIT    = 4;
    localparam int          BUS_CAN_LSB      = 0;
    localparam int          BUS_CAN_SWK_BIT  = 2;
    // transceiver mode codes
    localparam logic [1:0]  MODE_OFF         = 2'h0;
    localparam logic [1:0]  MODE_WAKE        = 2'h1;
    localparam logic [1:0]  MODE_RECV        = 2'h2;
    localparam logic [1:0]  MODE_NORMAL      = 2'h3;
    // watchdog periods in ms, codes 0 to 7
    localparam int          PER_MS_0         = 10;
    localparam int          PER_MS_1         = 20;
    localparam int          PER_MS_2         = 50;
    localparam int          PER_MS_3         = 100;
    localparam int          PER_MS_4         = 200;
    localparam int          PER_MS_5         = 500;
    localparam int          PER_MS_6         = 1000;
    localparam int          PER_MS_7         = 10000;
    localparam int          CLK_HZ           = 100_000_000;
    localparam int          TICKS_PER_MS     = CLK_HZ / 1000;
endpackage

/* File: rtl/sbc_reset_sync.sv */
/*
 reset synchroniser: asynchronous assertion, release through two flops.
 assumes rstn is an active-low asynchronous input.
*/
`timescale 1ns/1ns
module sbc_reset_sync (
    input  wire logic sys_clk,
    input  wire logic rstn,
    output logic      rst_n
);
    logic stage;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            stage <= 1'b1;
            rst_n <= stage;
        end
    end
endmodule

/* File: rtl/sbc_wdog_period.sv */
/*
 watchdog period decoder: period code to a registered count of cycles.
 assumes a synchronised active-low reset on the same clock.
*/
`timescale 1ns/1ns
module sbc_wdog_period #(
    parameter int TICKS_PER_MS = sbc_pkg::TICKS_PER_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  period_sel,
    output logic      [29:0] period_cycles
);
    function automatic logic [29:0] to_cycles(input logic [2:0] code);
        int ms;
        ms = sbc_pkg::PER_MS_0;
        case (code)
            3'h0: ms = sbc_pkg::PER_MS_0;
            3'h1: ms = sbc_pkg::PER_MS_1;
            3'h2: ms = sbc_pkg::PER_MS_2;
            3'h3: ms = sbc_pkg::PER_MS_3;
            3'h4: ms = sbc_pkg::PER_MS_4;
            3'h5: ms = sbc_pkg::PER_MS_5;
            3'h6: ms = sbc_pkg::PER_MS_6;
            default: ms = sbc_pkg::PER_MS_7;
        endcase
        to_cycles = 30'(ms * TICKS_PER_MS);
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cycles <= 30'h0;
        end else begin
            period_cycles <= to_cycles(period_sel);
        end
    end
endmodule

/* File: tb/sbc_checker.sv */
/*
 port checker for the control register bank: restart, fail output,
 stop exit, sleep, fail-safe and bus-wake behaviour.
 assumes it is bound to sbc_ctrl_regs, one clock, async active-low reset.
*/
`timescale 1ns/1ns
module sbc_checker (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic       soft_reset_evt,
    input wire logic       restart_entry,
    input wire logic       stop_to_normal,
    input wire logic       sleep_entry,
    input wire logic       failsafe_entry,
    input wire logic       bus_wake_in_stop,
    input wire logic       system_error_config,
    input wire logic       failure_active,
    input wire logic       restart_lin_wake,
    input wire logic       dev_bus_upd,
    input wire logic       thermal_wait_select,
    input wire logic       reset_delay_select,
    input wire logic       stop_wdog_disable_hi,
    input wire logic       fail_output,
    input wire logic       wdog_start_on_bus_wake,
    input wire logic [2:0] wdog_period_select,
    input wire logic       wdog_start_long_window,
    input wire logic [1:0] lin_mode,
    input wire logic [1:0] can_mode,
    input wire logic       selective_wake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // overriding events and host bus writes
    wire ovr = soft_reset_evt || restart_entry || failsafe_entry;
    wire bus_host = reg_wr && reg_addr == sbc_pkg::ADDR_BUS;
    sequence restart_s;
        restart_entry && !soft_reset_evt;
    endsequence
    sequence restart_quiet_s;
        restart_s ##1 !failure_active;
    endsequence
    restart_hw_a: assert property (restart_s |=> !stop_wdog_disable_hi &&
        thermal_wait_select == $past(thermal_wait_select) &&
        reset_delay_select == $past(reset_delay_select))
        else $error("hardware setup wrong after restart");
    restart_wd_a: assert property (restart_s |=> wdog_period_select ==
        3'h4 && wdog_start_on_bus_wake == $past(wdog_start_on_bus_wake))
        else $error("watchdog control wrong after restart");
    restart_bus_a: assert property (restart_s |=> can_mode == 2'h0 &&
        lin_mode == {$past(restart_lin_wake), 1'b0} && $stable(selective_wake))
        else $error("bus control wrong after restart");
    fail_quiet_a: assert property (restart_quiet_s |=> !fail_output)
        else $error("fail output still on after restart");
    fail_on_a: assert property (failure_active |=> fail_output)
        else $error("fail output off during failure");
    stop_clear_a: assert property (stop_to_normal &&
        !(reg_wr && reg_addr == sbc_pkg::ADDR_HW) |=> !stop_wdog_disable_hi)
        else $error("stop disable bit kept after stop exit");
    sleep_wake_a: assert property (sleep_entry && !system_error_config &&
        can_mode[1] && !ovr && !dev_bus_upd && !bus_host |=>
        can_mode == sbc_pkg::MODE_WAKE && $stable(selective_wake))
        else $error("can mode not wake capable after sleep");
    dev_can_a: assert property (dev_bus_upd && !ovr && !bus_host |=>
        $stable(selective_wake))
        else $error("device changed selective wake bit");
    failsafe_a: assert property (failsafe_entry && !soft_reset_evt &&
        !restart_entry |=> lin_mode == 2'h1 && !selective_wake &&
        can_mode == 2'h1)
        else $error("bus control not at fail-safe pattern");
    long_win_a: assert property (bus_wake_in_stop |=>
        wdog_start_long_window == $past(wdog_start_on_bus_wake))
        else $error("long window start wrong on bus wake");
endmodule

/* File: tb/sbc_host_model.sv */
/*
 host model: single-word register writes and reads on the strobe port.
 assumes calls at a falling edge and the read answer one cycle later.
*/
`timescale 1ns/1ns
module sbc_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rd_valid,
    output logic             reg_wr = 1'b0,
    output logic             reg_rd = 1'b0,
    output logic      [6:0]  reg_addr = 7'h7F,
    output logic      [15:0] reg_wdata = 16'h0000
);
    // whole word, checksum bit written as given
    task automatic write(input logic [6:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(negedge sys_clk);
    endtask
    task automatic read(input logic [6:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hBAD0;
        @(negedge sys_clk);
    endtask
endmodule

/* File: tb/testbench.sv */
/*
 testbench for the control register bank: register access, reset kinds,
 restart, device updates and mode events.
 assumes the host model and checker files compile before this one.
*/
`timescale 1ns/1ns
module testbench;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        soft_reset_evt, restart_entry, stop_to_normal, sleep_entry;
    logic        failsafe_entry, bus_wake_in_stop, dev_wd_upd, dev_bus_upd;
    logic        system_error_config, failure_active, fail_output_pin_cfg;
    logic        restart_lin_wake, dev_wd_stop_lo, dev_wd_start_bus;
    logic [2:0]  dev_wd_period;
    logic [1:0]  dev_lin_mode, dev_can_mode;
    wire         reg_wr, reg_rd, reg_rd_valid;
    wire  [6:0]  reg_addr;
    wire  [15:0] reg_wdata, reg_rdata;
    wire         thermal_wait_select, vs_ov_select, sample_hold_disable;
    wire         reset_delay_select, soft_reset_pin_option, fail_output;
    wire         stop_wdog_disable_hi, wdog_checksum, stop_wdog_disable_lo;
    wire         wdog_type_select, wdog_start_on_bus_wake, selective_wake;
    wire         wdog_start_long_window, lin_slope_off, lin_low_slope;
    wire         lin_tx_dominant_timeout;
    wire  [2:0]  wdog_period_select;
    wire  [29:0] wdog_period_cycles;
    wire  [1:0]  lin_mode, can_mode;
    wire  [15:0] hw_out = {3'h0, thermal_wait_select, vs_ov_select,
        sample_hold_disable, reset_delay_select, 2'h0, soft_reset_pin_option,
        3'h0, stop_wdog_disable_hi, 2'h0};
    wire  [15:0] wd_out = {wdog_checksum, 8'h00, stop_wdog_disable_lo,
        wdog_type_select, wdog_start_on_bus_wake, 1'b0, wdog_period_select};
    wire  [15:0] bus_out = {8'h00, lin_slope_off, lin_low_slope,
        lin_tx_dominant_timeout, lin_mode, selective_wake, can_mode};
    logic [15:0] per_ms [8] = '{16'h000A, 16'h0014, 16'h0032, 16'h0064,
        16'h00C8, 16'h01F4, 16'h03E8, 16'h2710};
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    sbc_ctrl_regs #(.TICKS_PER_MS(1)) dut (.*);
    sbc_host_model host (.*);

    always #5 sys_clk = ~sys_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.read(a, d);
        check(d, exp);
    endtask
    // one-cycle pulse on the event and update strobes
    task automatic pulse(input logic [7:0] m);
        {dev_bus_upd, dev_wd_upd, bus_wake_in_stop, failsafe_entry,
            sleep_entry, stop_to_normal, restart_entry, soft_reset_evt} = m;
        @(negedge sys_clk);
        {dev_bus_upd, dev_wd_upd, bus_wake_in_stop, failsafe_entry,
            sleep_entry, stop_to_normal, restart_entry, soft_reset_evt} = '0;
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        {system_error_config, failure_active, fail_output_pin_cfg,
            restart_lin_wake, dev_wd_stop_lo, dev_wd_start_bus, dev_wd_period,
            dev_lin_mode, dev_can_mode} = '0;
        pulse(8'h00);
        repeat (15) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        rdchk(sbc_pkg::ADDR_HW, 16'h0000);
        rdchk(sbc_pkg::ADDR_WD, 16'h0014);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0000);
        host.write(7'h10, 16'hFFFF);
        rdchk(7'h10, 16'h0000);
        host.write(sbc_pkg::ADDR_WD, 16'hFFFF);
        rdchk(sbc_pkg::ADDR_WD, 16'h8077);
        check(wd_out, 16'h8077);
        for (int i = 0; i < 8; i++) begin
            host.write(sbc_pkg::ADDR_WD, {13'h0000, i[2:0]});
            check(wdog_period_cycles[15:0], per_ms[i]);
            host.write(sbc_pkg::ADDR_BUS, {11'h000, i[1:0], i[2:0]});
            check(bus_out, {11'h000, i[1:0], i[2:0]});
        end
        host.write(sbc_pkg::ADDR_BUS, 16'hFFFF);
        rdchk(sbc_pkg::ADDR_BUS, 16'h00FF);
        check(bus_out, 16'h00FF);
        {fail_output_pin_cfg, restart_lin_wake} = 2'h3;
        host.write(sbc_pkg::ADDR_HW, 16'hFFFF);
        host.write(sbc_pkg::ADDR_WD, 16'hFFFF);
        rdchk(sbc_pkg::ADDR_HW, 16'h1E64);
        check(hw_out, 16'h1E44);
        check({15'h0000, fail_output}, 16'h0001);
        pulse(8'h02);
        rdchk(sbc_pkg::ADDR_HW, 16'h1240);
        rdchk(sbc_pkg::ADDR_WD, 16'h0014);
        rdchk(sbc_pkg::ADDR_BUS, 16'h00D4);
        check({15'h0000, fail_output}, 16'h0000);
        restart_lin_wake = 1'b0;
        host.write(sbc_pkg::ADDR_WD, 16'h0000);
        pulse(8'h02);
        rdchk(sbc_pkg::ADDR_WD, 16'h0004);
        rdchk(sbc_pkg::ADDR_BUS, 16'h00C4);
        failure_active = 1'b1;
        host.write(sbc_pkg::ADDR_HW, 16'h0020);
        host.write(sbc_pkg::ADDR_HW, 16'h0000);
        check({15'h0000, fail_output}, 16'h0001);
        failure_active = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({15'h0000, fail_output}, 16'h0000);
        host.write(sbc_pkg::ADDR_HW, 16'hFFFF);
        host.write(sbc_pkg::ADDR_WD, 16'hFFFF);
        host.write(sbc_pkg::ADDR_BUS, 16'hFFFF);
        pulse(8'h01);
        rdchk(sbc_pkg::ADDR_HW, 16'h0200);
        rdchk(sbc_pkg::ADDR_WD, 16'h0014);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0000);
        host.write(sbc_pkg::ADDR_HW, 16'h0004);
        pulse(8'h04);
        rdchk(sbc_pkg::ADDR_HW, 16'h0000);
        {dev_wd_stop_lo, dev_wd_start_bus, dev_wd_period} = 5'h17;
        pulse(8'h40);
        rdchk(sbc_pkg::ADDR_WD, 16'h0047);
        host.write(sbc_pkg::ADDR_BUS, 16'h0007);
        pulse(8'h08);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0005);
        host.write(sbc_pkg::ADDR_BUS, 16'h0006);
        pulse(8'h08);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0005);
        system_error_config = 1'b1;
        host.write(sbc_pkg::ADDR_BUS, 16'h0003);
        pulse(8'h08);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0003);
        host.write(sbc_pkg::ADDR_BUS, 16'h0007);
        dev_lin_mode = 2'h2;
        pulse(8'h80);
        rdchk(sbc_pkg::ADDR_BUS, 16'h0014);
        host.write(sbc_pkg::ADDR_BUS, 16'h00FF);
        pulse(8'h10);
        rdchk(sbc_pkg::ADDR_BUS, 16'h00E9);
        host.write(sbc_pkg::ADDR_WD, 16'h0010);
        pulse(8'h20);
        check({15'h0000, wdog_start_long_window}, 16'h0001);
        host.write(sbc_pkg::ADDR_WD, 16'h0000);
        pulse(8'h20);
        check({15'h0000, wdog_start_long_window}, 16'h0000);
        wrap_up();
    end
endmodule

bind sbc_ctrl_regs sbc_checker chk (.*);
